// ### rtl/mprl_pkg.sv
// Purpose: Shared constants and packet carriers for the maintenance and route lookup block
// Assumes: Header fields arrive already parsed from the serial link, one header per beat
// Notes: 8-bit destination IDs sit in the low byte of dst_id and src_id
package mprl_pkg;

  // ----------------------------------------
  // Packet field codes
  // ----------------------------------------
  localparam logic [3:0] FTYPE_MAINT = 4'h8;
  localparam logic [1:0] TT_16BIT = 2'h1;
  localparam logic [3:0] TTYPE_RD = 4'h0;
  localparam logic [3:0] TTYPE_WR = 4'h1;
  localparam logic [3:0] TTYPE_RD_RSP = 4'h2;
  localparam logic [3:0] TTYPE_WR_RSP = 4'h3;
  localparam logic [3:0] STATUS_DONE = 4'h0;
  localparam logic [7:0] HOP_LOCAL = 8'h00;
  localparam logic [7:0] HOP_RSP = 8'hFF;
  localparam logic [1:0] PRIO_TOP = 2'h3;

  // ----------------------------------------
  // Route entry encoding
  // ----------------------------------------
  localparam logic [1:0] REGION_PORT = 2'h0;
  localparam logic [1:0] REGION_MCAST = 2'h1;
  localparam logic [7:0] ENT_DEFAULT = 8'hDE;
  localparam logic [7:0] ENT_NOROUTE = 8'hDF;
  localparam logic [7:0] ENT_LOCAL = 8'hDD;
  localparam int TABLE_DEPTH = 256;
  localparam int ENTRY_W = 8;
  localparam int PORT_W = 4;

  // ----------------------------------------
  // Configuration address map
  // ----------------------------------------
  localparam logic [23:0] ADDR_DOMAIN = 24'hF20020;
  localparam logic [23:0] ADDR_DEF_PORT = 24'h000078;
  localparam logic [7:0] PAGE_GLOBAL = 8'hE0;
  localparam logic [7:0] PAGE_LOCAL = 8'hE1;
  localparam logic [1:0] SEL_DEV = 2'h0;
  localparam logic [1:0] SEL_DOM = 2'h2;
  localparam logic [31:0] DOMAIN_RST = 32'h0000_0000;
  localparam logic [3:0] DEF_PORT_RST = 4'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] rsvd;
    logic crf;
    logic [1:0] prio;
    logic [1:0] tt;
    logic [3:0] ftype;
    logic [15:0] dst_id;
    logic [15:0] src_id;
    logic [3:0] ttype;
    logic [3:0] size;
    logic [7:0] tid;
    logic [7:0] hop;
    logic [20:0] cfg_ofs;
    logic wptr;
    logic [31:0] data;
  } mprl_hdr_t;

  typedef struct packed {
    mprl_hdr_t hdr;
    logic [3:0] out_port;
    logic mcast;
    logic crc_regen;
    logic is_resp;
  } mprl_egr_t;

endpackage

// ### rtl/mprl_route_mem.sv
// Purpose: All route tables, one write with a table mask, one registered read
// Assumes: Entry validity bits reset, storage does not
// Notes: An entry never written reads as the default-route code
`timescale 1ns/1ns
module mprl_route_mem #(
  parameter int NTAB = 10,
  parameter int DEPTH = 256,
  parameter int W = 8,
  parameter logic [7:0] FILL = 8'hDE
) (
  // Clock
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Write side
  input wire logic [NTAB-1:0] wr_mask,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  // Read side
  input wire logic [$clog2(NTAB)-1:0] rd_tab,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [NTAB*DEPTH];
  logic [NTAB*DEPTH-1:0] vld_r;
  int unsigned rd_a;

  assign rd_a = int'(rd_tab) * DEPTH + int'(rd_idx);

  // Validity bits give a reset to every entry without clearing storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vld_r <= '0;
    end else if (ce) begin
      for (int t = 0; t < NTAB; t++) begin
        if (wr_mask[t]) begin
          vld_r[t*DEPTH+int'(wr_idx)] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      for (int t = 0; t < NTAB; t++) begin
        if (wr_mask[t]) begin
          mem[t*DEPTH+int'(wr_idx)] <= wr_data;
        end
      end
      rd_data <= vld_r[rd_a] ? mem[rd_a] : FILL;
    end
  end
endmodule

// ### rtl/mprl_skid_buf.sv
// Purpose: Two-entry buffer between the lookup engine and the egress
// Assumes: Source honours in_ready, sink may stall any cycle
// Notes: Outputs come straight from registers
`timescale 1ns/1ns
module mprl_skid_buf #(
  parameter int W = 8
) (
  // Clock
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic skid_v_r;
  logic [W-1:0] skid_r;
  logic push;
  logic pop;

  assign push = in_valid & ~skid_v_r;
  assign pop = out_valid & out_ready;
  assign in_ready = ~skid_v_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      skid_v_r <= 1'b0;
      out_data <= '0;
      skid_r <= '0;
    end else if (ce) begin
      if (!out_valid || pop) begin
        if (skid_v_r) begin
          out_data <= skid_r;
          skid_v_r <= 1'b0;
        end else begin
          out_data <= in_data;
          out_valid <= push;
        end
      end else if (push) begin
        skid_r <= in_data;
        skid_v_r <= 1'b1;
      end
    end
  end
endmodule

// ### rtl/mprl_maint_route.sv
// Purpose: Maintenance packet handling and destination-ID route lookup for all ports
// Assumes: One parsed header per ingress beat, tagged with its ingress port
// Notes: Headers are taken one at a time; ingress stalls rather than drops
//
// What this block does
// - ftype 0b1000 marks a maintenance packet
// - hop count zero: terminate and execute access
// - hop above zero: decrement, regen CRC, forward
// - tt field picks 8 or 16 bit IDs
// - bad local ttype: discard and flag error
// - response leaves by the request's port
// - response hop count is 0xFF
// - copy rsvd, CRF, tt, ftype; TID turned
// - response prio plus one, capped at 3
// - response swaps source and destination IDs
// - response ttype matches, status zero, data
// - back-to-back local requests are never dropped
// - device and domain tables, 256x8, accessible
// - global write copies to all locals
// - local write touches only that table
// - lookups use only the port's tables
// - domain equal or zero: device table lookup
// - other domain: domain table by upper bits
// - force-local domain result redoes device lookup
// - 8-bit ID indexes table directly
// - entry gives port, mask, default, no-route
// - after reset all entries are default route
// - entry bits 7:6 select port or mask
// - default route goes to default port
`timescale 1ns/1ns
module mprl_maint_route #(
  parameter int NPORTS = 4
) (
  // Clock and control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Ingress headers
  input wire logic in_valid,
  input mprl_pkg::mprl_hdr_t in_hdr,
  input wire logic [3:0] in_port,
  output logic in_ready,
  // Egress packets
  output logic eg_valid,
  output mprl_pkg::mprl_egr_t eg_pkt,
  input wire logic eg_ready,
  // Events
  output logic err_ttype
);
  localparam int NSLOT = NPORTS + 1;
  localparam int NTAB = 2 * NSLOT;
  localparam int TAB_W = $clog2(NTAB);

  typedef enum logic [2:0] {S_IDLE, S_DOM, S_DEV, S_EMIT, S_CFG, S_RSP} mprl_state_t;

  function automatic logic [TAB_W-1:0] tnum(input logic dom, input int slot);
    tnum = TAB_W'((dom ? NSLOT : 0) + slot);
  endfunction

  mprl_state_t state_r, state_nxt;
  mprl_pkg::mprl_hdr_t hdr_r;
  logic [3:0] port_r;
  logic [7:0] ent_r;
  logic [31:0] dom_r;
  logic [3:0] defport_r;
  logic in_ready_r;
  logic err_r;

  // ----------------------------------------
  // Ingress classification
  // ----------------------------------------
  wire in_take = in_valid & in_ready_r;
  wire in_maint = in_hdr.ftype == mprl_pkg::FTYPE_MAINT;
  wire in_local = in_maint && in_hdr.hop == mprl_pkg::HOP_LOCAL;
  wire in_16 = in_hdr.tt == mprl_pkg::TT_16BIT;
  wire [7:0] in_hi = in_16 ? in_hdr.dst_id[15:8] : 8'h00;
  // Zero upper byte counts as in-domain too
  wire in_use_dom = in_hi != 8'h00 && in_hi != dom_r[7:0];

  // ----------------------------------------
  // Configuration address decode
  // ----------------------------------------
  wire [23:0] cfg_addr = {hdr_r.cfg_ofs, hdr_r.wptr, 2'b00};
  wire cfg_glob = cfg_addr[23:16] == mprl_pkg::PAGE_GLOBAL;
  wire cfg_loc = cfg_addr[23:16] == mprl_pkg::PAGE_LOCAL && int'(cfg_addr[15:12]) < NPORTS;
  wire cfg_sel_ok = cfg_addr[11:10] == mprl_pkg::SEL_DEV || cfg_addr[11:10] == mprl_pkg::SEL_DOM;
  wire cfg_tbl = (cfg_glob | cfg_loc) & cfg_sel_ok;
  wire cfg_dom = cfg_addr[11];
  wire [7:0] cfg_idx = cfg_addr[9:2];
  wire [3:0] cfg_slot = cfg_glob ? 4'(NPORTS) : cfg_addr[15:12];
  wire cfg_is_dreg = cfg_addr == mprl_pkg::ADDR_DOMAIN;
  wire cfg_is_dport = cfg_addr == mprl_pkg::ADDR_DEF_PORT;
  wire cfg_rd = hdr_r.ttype == mprl_pkg::TTYPE_RD;
  wire cfg_wr = hdr_r.ttype == mprl_pkg::TTYPE_WR;
  wire cfg_bad = !cfg_rd && !cfg_wr;
  wire cfg_wr_go = state_r == S_CFG && cfg_wr;

  // Global writes land in the global slot and every local slot of that kind;
  // a later write of either kind simply overwrites, so the latest wins
  logic [NTAB-1:0] wr_mask;
  always_comb begin
    wr_mask = '0;
    for (int s = 0; s < NSLOT; s++) begin
      if (cfg_wr_go && cfg_tbl && (cfg_glob || s == int'(cfg_slot))) begin
        wr_mask[tnum(cfg_dom, s)] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Route table read selection
  // ----------------------------------------
  // Lookups only ever address the ingress port's own slot, never the global one
  wire [TAB_W-1:0] rd_tab_look = tnum(in_use_dom, int'(in_port));
  wire [TAB_W-1:0] rd_tab_dev = tnum(1'b0, int'(port_r));
  wire [TAB_W-1:0] rd_tab_cfg = tnum(cfg_dom, int'(cfg_slot));
  // Keep the table read steady while a response waits on a stalled egress
  wire cfg_rd_hold = state_r == S_CFG || state_r == S_RSP;
  wire [TAB_W-1:0] rd_tab = state_r == S_DOM ? rd_tab_dev :
                            cfg_rd_hold ? rd_tab_cfg : rd_tab_look;
  wire [7:0] rd_idx = state_r == S_DOM ? hdr_r.dst_id[7:0] :
                      cfg_rd_hold ? cfg_idx :
                      in_use_dom ? in_hi : in_hdr.dst_id[7:0];
  logic [7:0] rd_data;

  mprl_route_mem #(
    .NTAB(NTAB),
    .DEPTH(mprl_pkg::TABLE_DEPTH),
    .W(mprl_pkg::ENTRY_W),
    .FILL(mprl_pkg::ENT_DEFAULT)
  ) u_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_mask(wr_mask),
    .wr_idx(cfg_idx),
    .wr_data(hdr_r.data[7:0]),
    .rd_tab(rd_tab),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Route entry decode
  // ----------------------------------------
  wire ent_default = ent_r == mprl_pkg::ENT_DEFAULT;
  wire ent_port = ent_r[7:6] == mprl_pkg::REGION_PORT;
  wire ent_mcast = ent_r[7:6] == mprl_pkg::REGION_MCAST;
  // Unknown codes are dropped like no-route rather than guessed at
  wire ent_ok = ent_default | ent_port | ent_mcast;

  // ----------------------------------------
  // Egress word build
  // ----------------------------------------
  mprl_pkg::mprl_egr_t fwd_pkt, rsp_pkt, buf_in;
  logic [31:0] rsp_data;
  wire fwd_maint = hdr_r.ftype == mprl_pkg::FTYPE_MAINT;

  always_comb begin
    fwd_pkt = '0;
    fwd_pkt.hdr = hdr_r;
    if (fwd_maint) begin
      fwd_pkt.hdr.hop = hdr_r.hop - 8'h01;
    end
    fwd_pkt.crc_regen = fwd_maint;
    fwd_pkt.mcast = ent_mcast && !ent_default;
    fwd_pkt.out_port = ent_default ? defport_r : ent_r[3:0];
  end

  assign rsp_data = cfg_tbl ? {24'h000000, rd_data} :
                    cfg_is_dreg ? dom_r :
                    cfg_is_dport ? {28'h0000000, defport_r} : 32'h00000000;

  always_comb begin
    rsp_pkt = '0;
    rsp_pkt.hdr = hdr_r;
    rsp_pkt.hdr.prio = hdr_r.prio == mprl_pkg::PRIO_TOP ? hdr_r.prio : hdr_r.prio + 2'h1;
    rsp_pkt.hdr.dst_id = hdr_r.src_id;
    rsp_pkt.hdr.src_id = hdr_r.dst_id;
    rsp_pkt.hdr.ttype = cfg_rd ? mprl_pkg::TTYPE_RD_RSP : mprl_pkg::TTYPE_WR_RSP;
    rsp_pkt.hdr.size = mprl_pkg::STATUS_DONE;
    rsp_pkt.hdr.hop = mprl_pkg::HOP_RSP;
    rsp_pkt.hdr.data = cfg_rd ? rsp_data : 32'h00000000;
    rsp_pkt.out_port = port_r;
    rsp_pkt.is_resp = 1'b1;
  end

  wire buf_push = state_r == S_RSP || (state_r == S_EMIT && ent_ok);
  wire buf_ready;
  assign buf_in = state_r == S_RSP ? rsp_pkt : fwd_pkt;
  wire buf_take = buf_push & buf_ready;

  mprl_skid_buf #(
    .W($bits(mprl_pkg::mprl_egr_t))
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(buf_push),
    .in_data(buf_in),
    .in_ready(buf_ready),
    .out_valid(eg_valid),
    .out_data(eg_pkt),
    .out_ready(eg_ready)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // A stalled egress holds the state, so ingress backs up instead of losing headers
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (in_take) begin
          state_nxt = in_local ? S_CFG : (in_use_dom ? S_DOM : S_DEV);
        end
      end
      S_DOM: begin
        state_nxt = rd_data == mprl_pkg::ENT_LOCAL ? S_DEV : S_EMIT;
      end
      S_DEV: begin
        state_nxt = S_EMIT;
      end
      S_EMIT: begin
        if (!ent_ok || buf_ready) begin
          state_nxt = S_IDLE;
        end
      end
      S_CFG: begin
        state_nxt = cfg_bad ? S_IDLE : S_RSP;
      end
      S_RSP: begin
        if (buf_ready) begin
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      hdr_r <= '0;
      port_r <= 4'h0;
      ent_r <= mprl_pkg::ENT_DEFAULT;
      in_ready_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      in_ready_r <= state_nxt == S_IDLE && !in_take;
      err_r <= state_r == S_CFG && cfg_bad;
      if (in_take) begin
        hdr_r <= in_hdr;
        port_r <= in_port;
      end
      if ((state_r == S_DOM && rd_data != mprl_pkg::ENT_LOCAL) || state_r == S_DEV) begin
        ent_r <= rd_data;
      end
    end
  end

  // Configuration registers written by local maintenance writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dom_r <= mprl_pkg::DOMAIN_RST;
      defport_r <= mprl_pkg::DEF_PORT_RST;
    end else if (ce && cfg_wr_go) begin
      if (cfg_is_dreg) begin
        dom_r <= hdr_r.data;
      end
      if (cfg_is_dport) begin
        defport_r <= hdr_r.data[3:0];
      end
    end
  end

  assign in_ready = in_ready_r;
  assign err_ttype = err_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_MAINT_CLASS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && state_r == S_IDLE && in_take && in_hdr.ftype != mprl_pkg::FTYPE_MAINT)
      |=> state_r != S_CFG)
    else $error("non-maintenance header went to local access");
  AST_LOCAL_TERM: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && state_r == S_IDLE && in_take && in_local) |=> state_r == S_CFG)
    else $error("hop zero maintenance header not terminated");
  AST_FWD_HOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_EMIT && fwd_maint)
      |-> buf_in.hdr.hop == hdr_r.hop - 8'h01 && buf_in.crc_regen)
    else $error("forwarded maintenance hop not decremented");
  AST_BAD_TTYPE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && state_r == S_CFG && cfg_bad) |=> err_ttype && state_r == S_IDLE && !buf_push)
    else $error("bad ttype not discarded with error");
  AST_RSP_PORT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_RSP) |-> buf_in.out_port == port_r && buf_in.is_resp)
    else $error("response not sent to ingress port");
  AST_RSP_HOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (eg_valid && eg_pkt.is_resp) |-> eg_pkt.hdr.hop == 8'hFF)
    else $error("response hop count not 0xFF");
  AST_RSP_PRIO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_RSP)
      |-> buf_in.hdr.prio == (hdr_r.prio == 2'h3 ? 2'h3 : hdr_r.prio + 2'h1))
    else $error("response priority wrong");
  AST_RSP_SWAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_RSP)
      |-> buf_in.hdr.dst_id == hdr_r.src_id && buf_in.hdr.src_id == hdr_r.dst_id)
    else $error("response IDs not swapped");
  AST_RSP_STATUS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (eg_valid && eg_pkt.is_resp) |-> eg_pkt.hdr.size == 4'h0)
    else $error("response status not zero");
  AST_NOROUTE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && state_r == S_EMIT && ent_r == mprl_pkg::ENT_NOROUTE) |-> !buf_push ##1 state_r == S_IDLE)
    else $error("no-route packet was forwarded");
  AST_RSP_COPY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_RSP)
      |-> buf_in.hdr.rsvd == hdr_r.rsvd && buf_in.hdr.crf == hdr_r.crf
        && buf_in.hdr.tt == hdr_r.tt && buf_in.hdr.ftype == hdr_r.ftype
        && buf_in.hdr.tid == hdr_r.tid)
    else $error("response did not copy request fields");
  AST_RSP_TTYPE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_RSP)
      |-> buf_in.hdr.ttype == (cfg_rd ? 4'h2 : 4'h3))
    else $error("response transaction type wrong");
  AST_LOOK_LOCAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && in_take) |-> rd_tab != tnum(1'b0, NPORTS) && rd_tab != tnum(1'b1, NPORTS))
    else $error("lookup addressed a global table");
  AST_DEV_LOOK: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && in_take && !in_local && in_16 && in_hdr.dst_id[15:8] == dom_r[7:0])
      |=> state_r == S_DEV)
    else $error("in-domain ID did not use device table");
  AST_DOM_LOOK: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && in_take && !in_local && in_16 && in_hdr.dst_id[15:8] != 8'h00
      && in_hdr.dst_id[15:8] != dom_r[7:0]) |=> state_r == S_DOM)
    else $error("foreign domain ID did not use domain table");
  AST_DIRECT_ID: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && in_take && !in_local && !in_16)
      |-> rd_idx == in_hdr.dst_id[7:0] ##1 state_r == S_DEV)
    else $error("8-bit ID not used as direct index");
  AST_DEF_PORT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (buf_take && state_r == S_EMIT && ent_default)
      |-> buf_in.out_port == defport_r && !buf_in.mcast)
    else $error("default route not sent to default port");
endmodule

// ### testbench/mprl_link_sink.sv
// Purpose: Link partner model that drains the egress side of the block
// Assumes: One word is taken per edge with valid and ready both high
// Notes: Answers promptly, slowly (one edge in four) or not at all
`timescale 1ns/1ns
module mprl_link_sink (
  // Clock
  input wire logic core_clk,
  input wire logic rst_n,
  // Egress
  input wire logic eg_valid,
  input mprl_pkg::mprl_egr_t eg_pkt,
  output logic eg_ready,
  // Pace
  input wire logic slow,
  input wire logic hold
);
  mprl_pkg::mprl_egr_t rx_q[$];
  logic [1:0] pace_r;

  // Ready is registered, so a stall also tests the buffer's second entry
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pace_r <= 2'h0;
      eg_ready <= 1'b0;
    end else begin
      pace_r <= pace_r + 2'h1;
      eg_ready <= !hold && (!slow || pace_r == 2'h0);
      if (eg_valid && eg_ready) begin
        rx_q.push_back(eg_pkt);
      end
    end
  end
endmodule

// ### testbench/maint_packet_and_route_lookup_test.sv
// Purpose: Self-checking bench for the maintenance and route lookup block
// Assumes: Four ports; the partner model drains the egress side
// Notes: Table rows hold ordinary accesses; stall, bad type and reset follow
`timescale 1ns/1ns
module maint_packet_and_route_lookup_test;
  typedef struct packed {
    logic [1:0] op;
    logic [3:0] p;
    logic [23:0] a;
    logic [7:0] d;
  } mprl_row_t;

  // ----------------------------------------
  // Stimulus table
  // ----------------------------------------
  // Op 0 write, 1 read, 2 forward 8-bit ID, 3 forward 16-bit ID; a[23:16] is hop
  localparam mprl_row_t ROWS [30] = '{
    '{2'h1, 4'h0, 24'hE00014, 8'hDE}, '{2'h1, 4'h1, 24'hF20020, 8'h00},
    '{2'h2, 4'h2, 24'h000005, 8'hDE}, '{2'h0, 4'h0, 24'hE00014, 8'h03},
    '{2'h1, 4'h3, 24'hE12014, 8'h03}, '{2'h2, 4'h1, 24'h050005, 8'h03},
    '{2'h0, 4'h1, 24'hE11014, 8'h42}, '{2'h1, 4'h0, 24'hE00014, 8'h03},
    '{2'h1, 4'h2, 24'hE12014, 8'h03}, '{2'h2, 4'h1, 24'h000005, 8'h42},
    '{2'h2, 4'h0, 24'h000005, 8'h03}, '{2'h0, 4'h2, 24'hE00014, 8'h07},
    '{2'h1, 4'h3, 24'hE11014, 8'h07}, '{2'h0, 4'h0, 24'hE10018, 8'hDF},
    '{2'h2, 4'h0, 24'h000006, 8'hDF}, '{2'h2, 4'h1, 24'h020006, 8'hDE},
    '{2'h0, 4'h0, 24'hF20020, 8'h12}, '{2'h1, 4'h3, 24'hF20020, 8'h12},
    '{2'h0, 4'h1, 24'hE008D0, 8'h09}, '{2'h0, 4'h1, 24'hE008D4, 8'hDD},
    '{2'h0, 4'h1, 24'hE001DC, 8'h0B}, '{2'h3, 4'h2, 24'h001277, 8'h0B},
    '{2'h3, 4'h2, 24'h000077, 8'h0B}, '{2'h3, 4'h3, 24'h013477, 8'h09},
    '{2'h3, 4'h0, 24'h003577, 8'h0B}, '{2'h2, 4'h1, 24'h003477, 8'h0B},
    '{2'h0, 4'h0, 24'hE30000, 8'h55}, '{2'h1, 4'h0, 24'hE30000, 8'h00},
    '{2'h0, 4'h3, 24'h000078, 8'h02}, '{2'h2, 4'h3, 24'h0000AA, 8'hDE}
  };

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic in_valid = 1'b0;
  mprl_pkg::mprl_hdr_t in_hdr = '0;
  logic [3:0] in_port = 4'h0;
  logic in_ready, eg_valid, eg_ready, err_ttype;
  mprl_pkg::mprl_egr_t eg_pkt;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic [3:0] def_port = mprl_pkg::DEF_PORT_RST;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int errs = 0;

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  mprl_maint_route #(.NPORTS(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .in_valid(in_valid), .in_hdr(in_hdr), .in_port(in_port), .in_ready(in_ready),
    .eg_valid(eg_valid), .eg_pkt(eg_pkt), .eg_ready(eg_ready), .err_ttype(err_ttype));

  mprl_link_sink sink_u (.core_clk(core_clk), .rst_n(rst_n), .eg_valid(eg_valid),
    .eg_pkt(eg_pkt), .eg_ready(eg_ready), .slow(slow), .hold(hold));

  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (err_ttype === 1'b1) errs++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Checks and transfers
  // ----------------------------------------
  task automatic chk_pkt(string what, mprl_pkg::mprl_egr_t exp, mprl_pkg::mprl_egr_t got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_int(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic mprl_pkg::mprl_hdr_t mk(logic [3:0] ft, logic [1:0] tt,
      logic [15:0] dst, logic [3:0] ty, logic [7:0] hop, logic [23:0] a, logic [7:0] d,
      logic [1:0] pr);
    mprl_pkg::mprl_hdr_t h;
    h = '0;
    h.rsvd = 2'h2;
    h.crf = 1'b1;
    h.prio = pr;
    h.tt = tt;
    h.ftype = ft;
    h.dst_id = dst;
    h.src_id = 16'h0A5C;
    h.ttype = ty;
    h.size = 4'h8;
    h.tid = a[9:2];
    h.hop = hop;
    h.cfg_ofs = a[23:3];
    h.wptr = a[2];
    h.data = {24'h0, d};
    return h;
  endfunction

  // Header is held until the edge that samples ready high
  task automatic send(mprl_pkg::mprl_hdr_t h, logic [3:0] p);
    int n;
    n = 0;
    in_hdr <= h;
    in_port <= p;
    in_valid <= 1'b1;
    @(posedge core_clk);
    while (in_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    in_valid <= 1'b0;
    @(posedge core_clk);
    if (n == 100) chk_int("ingress take", 32'h1, 32'h0);
  endtask

  task automatic get(output mprl_pkg::mprl_egr_t w);
    int n;
    n = 0;
    while (sink_u.rx_q.size() == 0 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    w = (n < 100) ? sink_u.rx_q.pop_front() : '0;
  endtask

  // Offset, pointer and CRC flag of a response are left open, so both sides mask them
  task automatic chk_rsp(mprl_pkg::mprl_hdr_t h, logic [3:0] p, logic [31:0] rd);
    mprl_pkg::mprl_egr_t e, w;
    get(w);
    e = '0;
    e.hdr = h;
    e.hdr.prio = (h.prio == mprl_pkg::PRIO_TOP) ? h.prio : h.prio + 2'h1;
    e.hdr.dst_id = h.src_id;
    e.hdr.src_id = h.dst_id;
    e.hdr.ttype = h.ttype[0] ? mprl_pkg::TTYPE_WR_RSP : mprl_pkg::TTYPE_RD_RSP;
    e.hdr.size = mprl_pkg::STATUS_DONE;
    e.hdr.hop = mprl_pkg::HOP_RSP;
    e.hdr.cfg_ofs = '0;
    e.hdr.wptr = 1'b0;
    e.hdr.data = rd;
    e.out_port = p;
    e.is_resp = 1'b1;
    w.hdr.cfg_ofs = '0;
    w.hdr.wptr = 1'b0;
    w.crc_regen = 1'b0;
    chk_pkt("response", e, w);
  endtask

  task automatic cfg(logic [3:0] p, logic wr, logic [23:0] a, logic [7:0] d, logic [1:0] pr);
    mprl_pkg::mprl_hdr_t h;
    h = mk(mprl_pkg::FTYPE_MAINT, mprl_pkg::TT_16BIT, 16'h0100, {3'h0, wr},
      mprl_pkg::HOP_LOCAL, a, d, pr);
    send(h, p);
    chk_rsp(h, p, wr ? 32'h0 : {24'h0, d});
  endtask

  task automatic fwd(logic [3:0] p, logic [1:0] tt, logic [23:0] a, logic [7:0] ent);
    mprl_pkg::mprl_hdr_t h;
    mprl_pkg::mprl_egr_t e, w;
    h = mk((a[23:16] != 8'h00) ? mprl_pkg::FTYPE_MAINT : 4'h5, tt, a[15:0], 4'h4,
      a[23:16], 24'h0, 8'h00, 2'h1);
    send(h, p);
    if (ent == mprl_pkg::ENT_NOROUTE) begin
      repeat (12) @(posedge core_clk);
      chk_int("dropped", 32'h0, sink_u.rx_q.size());
    end else begin
      get(w);
      e = '0;
      e.hdr = h;
      e.hdr.hop = (h.hop == 8'h00) ? h.hop : h.hop - 8'h01;
      e.crc_regen = (h.hop != 8'h00);
      e.mcast = (ent[7:6] == mprl_pkg::REGION_MCAST);
      e.out_port = (ent == mprl_pkg::ENT_DEFAULT) ? def_port : ent[3:0];
      chk_pkt("forward", e, w);
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    mprl_pkg::mprl_hdr_t h;
    mprl_row_t r;
    int i;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 30; i++) begin
      r = ROWS[i];
      if (r.op[1]) fwd(r.p, {1'b0, r.op[0]}, r.a, r.d);
      else cfg(r.p, !r.op[0], r.a, r.d, i[1:0]);
      if (r.op == 2'h0 && r.a == mprl_pkg::ADDR_DEF_PORT) def_port = r.d[3:0];
    end
    // Sink stalls while requests keep coming; nothing may be lost
    hold <= 1'b1;
    h = mk(mprl_pkg::FTYPE_MAINT, mprl_pkg::TT_16BIT, 16'h0100, mprl_pkg::TTYPE_RD,
      mprl_pkg::HOP_LOCAL, 24'hE001DC, 8'h00, 2'h3);
    send(h, 4'h0);
    send(h, 4'h1);
    fork
      send(h, 4'h2);
      begin
        repeat (20) @(posedge core_clk);
        chk_int("stalled word", 32'h1, {31'h0, eg_valid});
        hold <= 1'b0;
        slow <= 1'b1;
      end
    join
    for (i = 0; i < 3; i++) chk_rsp(h, i[3:0], 32'h0B);
    for (i = 0; i < 2; i++) begin
      h.ttype = i[0] ? 4'hF : 4'h4;
      send(h, 4'h1);
      repeat (12) @(posedge core_clk);
    end
    chk_int("error pulses", 32'h2, errs);
    chk_int("discarded", 32'h0, sink_u.rx_q.size());
    cfg(4'h2, 1'b1, 24'hE00024, 8'h05, 2'h0);
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk_int("ready in reset", 32'h0, {31'h0, in_ready});
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    def_port = mprl_pkg::DEF_PORT_RST;
    cfg(4'h2, 1'b0, 24'hE00024, 8'hDE, 2'h0);
    fwd(4'h3, 2'h0, 24'h000009, 8'hDE);
    complete_run();
  end
endmodule
